// ==== core/jog_channel.sv ====
// Jog setpoint channel: sequencer, setpoint selection, ramp generator and Wishbone registers.
// Assumes one 250 MHz clock, pin commands asynchronous to it, and a classic Wishbone master.
//
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`include "jog_channel_map.svh"
`timescale 1ns/1ps
`default_nettype none
module jog_channel
(
   // Clock and reset.
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // Command pins from digital inputs, asynchronous.
   input wire jog_channel_pkg::cmd_s cmd_pins_i,
   // Wishbone classic slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Toward the speed controller.
   output jog_channel_pkg::speed_t speed_setpoint_o,
   output logic operation_enabled_status_bit_o,
   output logic freeze_missing_enable_o,
   output logic pos_eval_o
);
   import jog_channel_pkg::*;
   // ==========================================================================
   // Declarations
   cmd_s pin_meta, pin_sync; // Two-stage pin synchroniser.
   cmd_s cmd; // Effective commands.
   logic [15:0] ctrl, jog1, jog2, maxs, mainsp, sup1, sup2, mins, blo, bhi; // Software settings.
   logic [15:0] upst, dnst, qsst, cfg; // Ramp steps and configuration.
   logic [7:0] div; // Control-cycle divider.
   logic ctl_tick; // One pulse per control cycle.
   state_e state; // Sequencer state.
   speed_t speed; // Ramp generator output.
   speed_t tgt; // Target chosen for this cycle.
   speed_t next_speed; // Ramp result.
   logic [15:0] step; // Step chosen for this cycle.
   logic signed [16:0] diff; // Target minus speed.
   logic [31:0] rdata; // Read multiplexer.
   logic ext, jog_any, servo_ok, wr; // Helper terms.
   // ==========================================================================
   // Pin synchroniser; only the second stage is read.
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         pin_meta <= 6'b011000;
         pin_sync <= 6'b011000;
      end
      else
      begin
         pin_meta <= cmd_pins_i;
         pin_sync <= pin_meta;
      end
   end
   // Pins and the control word combine; either source can stop or jog the axis.
   always_comb
   begin
      cmd.on = pin_sync.on | ctrl[`CTRL_ON];
      cmd.coast_n = pin_sync.coast_n & ctrl[`CTRL_COAST_N];
      cmd.qstop_n = pin_sync.qstop_n & ctrl[`CTRL_QSTOP_N];
      cmd.freeze = pin_sync.freeze | ctrl[`CTRL_FREEZE];
      cmd.jog1 = pin_sync.jog1 | ctrl[`CTRL_JOG1];
      cmd.jog2 = pin_sync.jog2 | ctrl[`CTRL_JOG2];
   end
   assign ext = cfg[`CFG_EXT];
   assign jog_any = cmd.jog1 | cmd.jog2;
   assign servo_ok = cfg[`CFG_SERVO] && (cfg[15:8] == `TEL_STD5 || cfg[15:8] == `TEL_STD6);
   // ==========================================================================
   // Control-cycle divider; the sequencer only moves on its pulse.
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         div <= 8'h00;
         ctl_tick <= 1'b0;
      end
      else
      begin
         ctl_tick <= (div == 8'((`CTL_DIV) - 1));
         div <= (div == 8'((`CTL_DIV) - 1)) ? 8'h00 : div + 8'h01;
      end
   end
   // ==========================================================================
   // Setpoint shaping: direction, maximum, band and minimum.
   function automatic speed_t shape(input logic signed [17:0] x, input logic full);
      logic signed [17:0] v;
      logic [17:0] a;
      v = x;
      if (full && cfg[`CFG_INV])
      begin
         v = -v;
      end
      if (full && cfg[`CFG_NONEG] && v < 0)
      begin
         v = 18'sd0;
      end
      a = (v < 0) ? 18'(-v) : 18'(v);
      if (a > {2'b00, maxs})
      begin
         a = {2'b00, maxs};
      end
      if (a >= {2'b00, blo} && a < {2'b00, bhi})
      begin
         a = {2'b00, blo};
      end
      if (a < {2'b00, mins})
      begin
         a = {2'b00, mins};
      end
      shape = (v < 0) ? $signed(-a[15:0]) : $signed(a[15:0]);
   endfunction
   // Target for the present state; only jog speeds reach the ramp while jogging.
   always_comb
   begin
      tgt = 16'sh0000;
      case (state)
         S_RUN:
         begin
            if (ext)
            begin
               tgt = shape(18'($signed(mainsp)) + 18'($signed(sup1)) + 18'($signed(sup2)), 1'b1);
            end
            else
            begin
               tgt = $signed(sup1);
            end
         end
         S_JOG:
         begin
            if (cmd.jog1 && cmd.jog2)
            begin
               tgt = speed;
            end
            else if (cmd.jog1)
            begin
               tgt = shape(18'($signed(jog1)), 1'b0);
            end
            else if (cmd.jog2)
            begin
               tgt = shape(18'($signed(jog2)), 1'b0);
            end
         end
         default:
         begin
            tgt = 16'sh0000;
         end
      endcase
   end
   // Step choice: quick stop uses its own step, ramp stop the down step, otherwise up or down by direction of travel.
   always_comb
   begin
      diff = 17'($signed(tgt)) - 17'($signed(speed));
      if (state == S_QSTOP)
      begin
         step = qsst;
      end
      else if (state == S_RSTOP)
      begin
         step = dnst;
      end
      else if ((diff > 0) ? (speed >= 0) : (speed <= 0))
      begin
         step = upst;
      end
      else
      begin
         step = dnst;
      end
      if (diff > $signed({1'b0, step}))
      begin
         next_speed = 16'(speed + $signed(step));
      end
      else if (diff < -$signed({1'b0, step}))
      begin
         next_speed = 16'(speed - $signed(step));
      end
      else
      begin
         next_speed = tgt;
      end
   end
   // ==========================================================================
   // Sequencer; stops are checked first so nothing below can outrank them.
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         state <= S_READY;
      end
      else if (ctl_tick)
      begin
         if (!cmd.coast_n)
         begin
            state <= S_COAST;
         end
         else if (!cmd.qstop_n && state != S_READY && state != S_COAST)
         begin
            state <= S_QSTOP;
         end
         else
         begin
            case (state)
               S_READY:
               begin
                  if (cmd.qstop_n && cmd.on)
                  begin
                     state <= S_RUN;
                  end
                  else if (cmd.qstop_n && jog_any)
                  begin
                     state <= S_JOG;
                  end
               end
               S_RUN:
               begin
                  if (!cmd.on)
                  begin
                     state <= S_RSTOP;
                  end
               end
               S_RSTOP:
               begin
                  if (cmd.on)
                  begin
                     state <= S_RUN;
                  end
                  else if (jog_any)
                  begin
                     state <= S_JOG;
                  end
                  else if (speed == 16'sh0000)
                  begin
                     state <= S_READY;
                  end
               end
               S_JOG:
               begin
                  if (cmd.on)
                  begin
                     state <= S_RUN;
                  end
                  else if (!jog_any)
                  begin
                     state <= S_RSTOP;
                  end
               end
               S_QSTOP, S_COAST:
               begin
                  if (!cmd.on && cmd.qstop_n && (speed == 16'sh0000 || state == S_COAST))
                  begin
                     state <= S_READY;
                  end
               end
               default:
               begin
                  state <= S_READY;
               end
            endcase
         end
      end
   end
   // Ramp generator; without the extension the run setpoint passes straight through.
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         speed <= 16'sh0000;
      end
      else if (ctl_tick)
      begin
         if (state == S_COAST)
         begin
            speed <= 16'sh0000;
         end
         else if (state == S_RUN && !ext)
         begin
            speed <= tgt;
         end
         else if (!(state == S_RUN && cmd.freeze))
         begin
            speed <= next_speed;
         end
      end
   end
   // Registered outputs toward the speed controller.
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         speed_setpoint_o <= 16'sh0000;
         operation_enabled_status_bit_o <= 1'b0;
         freeze_missing_enable_o <= 1'b0;
         pos_eval_o <= 1'b0;
      end
      else
      begin
         speed_setpoint_o <= speed;
         operation_enabled_status_bit_o <= (state == S_RUN);
         freeze_missing_enable_o <= (state == S_JOG) && cmd.freeze;
         pos_eval_o <= ctl_tick && servo_ok;
      end
   end
   // ==========================================================================
   // Wishbone slave: one wait state, ack dropped in the following cycle.
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
   function automatic logic [15:0] lane(input logic [15:0] old);
      lane = {wb_sel_i[1] ? wb_dat_i[15:8] : old[15:8], wb_sel_i[0] ? wb_dat_i[7:0] : old[7:0]};
   endfunction
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ctrl <= `CTRL_RST;
         {jog1, jog2, mainsp, sup1, sup2, mins, blo, bhi} <= 128'h0;
         maxs <= `MAXS_RST;
         {upst, dnst, qsst} <= {3{`STEP_RST}};
         cfg <= 16'h0000;
      end
      else if (wr)
      begin
         case (wb_adr_i)
            `OFS_CTRL: ctrl <= lane(ctrl);
            `OFS_JOG1: jog1 <= lane(jog1);
            `OFS_JOG2: jog2 <= lane(jog2);
            `OFS_MAXS: maxs <= lane(maxs);
            `OFS_MAIN: mainsp <= lane(mainsp);
            `OFS_SUP1: sup1 <= lane(sup1);
            `OFS_SUP2: sup2 <= lane(sup2);
            `OFS_MINS: mins <= lane(mins);
            `OFS_BLO: blo <= lane(blo);
            `OFS_BHI: bhi <= lane(bhi);
            `OFS_UPST: upst <= lane(upst);
            `OFS_DNST: dnst <= lane(dnst);
            `OFS_QSST: qsst <= lane(qsst);
            `OFS_CFG: cfg <= lane(cfg);
            default: ctrl <= ctrl;
         endcase
      end
   end
   // Read multiplexer; unmapped addresses read zero.
   always_comb
   begin
      case (wb_adr_i)
         `OFS_CTRL: rdata = {16'h0, ctrl};
         `OFS_JOG1: rdata = {16'h0, jog1};
         `OFS_JOG2: rdata = {16'h0, jog2};
         `OFS_MAXS: rdata = {16'h0, maxs};
         `OFS_MAIN: rdata = {16'h0, mainsp};
         `OFS_SUP1: rdata = {16'h0, sup1};
         `OFS_SUP2: rdata = {16'h0, sup2};
         `OFS_MINS: rdata = {16'h0, mins};
         `OFS_BLO: rdata = {16'h0, blo};
         `OFS_BHI: rdata = {16'h0, bhi};
         `OFS_UPST: rdata = {16'h0, upst};
         `OFS_DNST: rdata = {16'h0, dnst};
         `OFS_QSST: rdata = {16'h0, qsst};
         `OFS_CFG: rdata = {16'h0, cfg};
         `OFS_STAT: rdata = {20'h0, servo_ok, freeze_missing_enable_o,
                             operation_enabled_status_bit_o, 3'h0, state};
         `OFS_SPD: rdata = {16'h0, speed};
         `OFS_CIND: rdata = 32'(ext) << `CIND_EXT;
         default: rdata = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         wb_dat_o <= rdata;
      end
   end
   // ==========================================================================
   // Assertions and covers.
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   tick_once_a: assert property (ctl_tick |=> !ctl_tick[*8]) else $error("tick too close");
   coast_wins_a: assert property (ctl_tick && !cmd.coast_n |=> state == S_COAST) else $error("coast");
   qstop_wins_a: assert property (ctl_tick && cmd.coast_n && !cmd.qstop_n && state == S_JOG
      |=> state == S_QSTOP) else $error("quick stop");
   jog_entry_a: assert property ($rose(state == S_JOG) |-> $past(state == S_READY || state == S_RSTOP))
      else $error("jog entered from wrong state");
   on_first_a: assert property (ctl_tick && state == S_READY && cmd.on && cmd.qstop_n && cmd.coast_n
      && jog_any |=> state == S_RUN) else $error("on lost to jog");
   hold_speed_a: assert property (ctl_tick && state == S_JOG && cmd.jog1 && cmd.jog2 && !cmd.on
      && cmd.coast_n && cmd.qstop_n |=> speed == $past(speed)) else $error("speed moved");
   jog_status_a: assert property (state == S_JOG |=> !operation_enabled_status_bit_o)
      else $error("status set in jog");
   freeze_flag_a: assert property (state == S_JOG && cmd.freeze |=> freeze_missing_enable_o)
      else $error("freeze flag");
   direct_sp_a: assert property (ctl_tick && state == S_RUN && !ext |=> speed == $past($signed(sup1)))
      else $error("direct setpoint");
   down_ramp_a: assert property (ctl_tick && state == S_RSTOP && speed > 0 && !cmd.on && !jog_any
      && cmd.coast_n && cmd.qstop_n |=> speed <= $past(speed)) else $error("ramp up in stop");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   jog_seen_c: cover property (state == S_JOG ##[1:1000] state == S_RSTOP);
   jog_to_run_c: cover property (state == S_JOG ##[1:1000] state == S_RUN);
   both_jog_c: cover property (state == S_JOG && cmd.jog1 && cmd.jog2);
endmodule // jog_channel
`default_nettype wire

// ==== core/jog_channel_map.svh ====
// Register offsets, field positions, reset values and timing counts of the jog setpoint channel.
// Assumes a 32-bit classic Wishbone slave with byte addresses and one word per register.
`ifndef JOG_CHANNEL_MAP_SVH
`define JOG_CHANNEL_MAP_SVH
// ==========================================================================
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_JOG1 8'h04
`define OFS_JOG2 8'h08
`define OFS_MAXS 8'h0c
`define OFS_MAIN 8'h10
`define OFS_SUP1 8'h14
`define OFS_SUP2 8'h18
`define OFS_MINS 8'h1c
`define OFS_BLO 8'h20
`define OFS_BHI 8'h24
`define OFS_UPST 8'h28
`define OFS_DNST 8'h2c
`define OFS_QSST 8'h30
`define OFS_CFG 8'h34
`define OFS_STAT 8'h38
`define OFS_SPD 8'h3c
`define OFS_CIND 8'h40
// ==========================================================================
// Field positions
`define CTRL_ON 0
`define CTRL_COAST_N 1
`define CTRL_QSTOP_N 2
`define CTRL_FREEZE 5
`define CTRL_JOG1 8
`define CTRL_JOG2 9
`define CFG_EXT 0
`define CFG_INV 1
`define CFG_NONEG 2
`define CFG_SERVO 3
`define CFG_TEL_LO 8
`define CIND_EXT 8
// ==========================================================================
// Reset values and telegram codes
`define CTRL_RST 16'h0006
`define MAXS_RST 16'h7fff
`define STEP_RST 16'h0001
`define TEL_STD5 8'h05
`define TEL_STD6 8'h06
// ==========================================================================
// Timing: one control cycle of 1000 ns at a 4 ns clock.
`define CLK_PERIOD_NS 4
`define CTL_CYCLE_NS 1000
`define CTL_DIV (`CTL_CYCLE_NS / `CLK_PERIOD_NS)
`endif

// ==== core/jog_channel_pkg.sv ====
// Types shared by the jog setpoint channel.
// Assumes nothing beyond a SystemVerilog compiler.
package jog_channel_pkg;
   // Command bits as seen by the sequencer; stops are active low.
   typedef struct packed {
      logic on;
      logic coast_n;
      logic qstop_n;
      logic freeze;
      logic jog1;
      logic jog2;
   } cmd_s;
   // Drive sequencer states, one-hot.
   typedef enum logic [5:0] {
      S_READY = 6'b000001,
      S_RUN = 6'b000010,
      S_RSTOP = 6'b000100,
      S_JOG = 6'b001000,
      S_QSTOP = 6'b010000,
      S_COAST = 6'b100000
   } state_e;
   // Signed speed value.
   typedef logic signed [15:0] speed_t;
endpackage

// ==== tb/cmd_source.sv ====
// Command source model: stands in for the controller or the digital command inputs.
// Assumes the test sequence sets the wanted command word; pins move just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module cmd_source
(
   // Clock and reset.
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // Wanted command from the test sequence.
   input wire jog_channel_pkg::cmd_s want_i,
   // Command pins toward the drive.
   output jog_channel_pkg::cmd_s cmd_pins_o
);
   import jog_channel_pkg::*;
   // ==========================================================================
   // Pin driver
   // The pins follow the wanted word one edge late, like a registered controller output.
   // Stops idle released (high) so a reset of the source never looks like a stop command.
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         cmd_pins_o <= 6'h18;
      else
         cmd_pins_o <= want_i;
   end
endmodule // cmd_source
`default_nettype wire

// ==== tb/jog_setpoint_channel_control_tb.sv ====
// Self-checking bench of the jog setpoint channel: Wishbone tasks and pin command sequences.
// Assumes a 250 MHz clock and a control tick every CTL_DIV clocks, as the map header gives.
`include "jog_channel_map.svh"
`timescale 1ns/1ps
`default_nettype none
module jog_setpoint_channel_control_tb;
   import jog_channel_pkg::*;
   // ==========================================================================
   // Signals
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, rd;
   logic ack, op_en, frz, pos;
   speed_t spd;
   cmd_s want = 6'h18, pins; // Stops released, nothing else asserted.
   int num_errors = 0, checked = 0, cycles = 0, pulses = 0, p0;
   // ==========================================================================
   // Clock, partner and device
   always #2 clk = ~clk;
   cmd_source host (.sys_clk_i(clk), .resetn_i(rst_n), .want_i(want), .cmd_pins_o(pins));
   // Only lanes 0 and 1 carry register bits, so both byte enables stay on.
   jog_channel dut (.sys_clk_i(clk), .resetn_i(rst_n), .cmd_pins_i(pins), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .speed_setpoint_o(spd),
      .operation_enabled_status_bit_o(op_en), .freeze_missing_enable_o(frz),
      .pos_eval_o(pos));
   // Position pulses are counted on the falling edge, away from the bench's sampling edge.
   always @(negedge clk)
      if (pos === 1'b1)
         pulses++;
   // A hang is cut short well above the expected run of about 28000 clocks.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         num_errors++;
         conclude();
      end
   end
   // ==========================================================================
   // Tasks
   task automatic conclude();
      if (num_errors == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One classic cycle; the request holds until ack is seen high at an edge.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do
         @(posedge clk);
      while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      cmp(rd & m, e);
   endtask
   task automatic tick(input int n);
      repeat (n * `CTL_DIV) @(posedge clk);
   endtask
   // ==========================================================================
   // Sequence
   initial
   begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      // Reset values, read-only status and an unmapped place.
      chk(`OFS_CTRL, 32'hffff, 32'h6);
      chk(`OFS_MAXS, 32'hffffffff, 32'h7fff);
      chk(`OFS_CFG, 32'hffff, 32'h0);
      chk(`OFS_CIND, 32'h100, 32'h0);
      wr(`OFS_STAT, 32'hffff);
      chk(`OFS_STAT, 32'h63f, 32'h1);
      wr(8'h44, 32'h1234);
      chk(8'h44, 32'hffffffff, 32'h0);
      // Speeds and ramp steps; the extension sums 500 + 100 - 50.
      wr(`OFS_JOG1, 32'd100);
      wr(`OFS_JOG2, 32'hff38);
      wr(`OFS_UPST, 32'd50);
      wr(`OFS_DNST, 32'd25);
      wr(`OFS_QSST, 32'd100);
      wr(`OFS_MAIN, 32'd300);
      wr(`OFS_SUP1, 32'd100);
      wr(`OFS_SUP2, 32'hffce);
      wr(`OFS_CFG, 32'h1);
      chk(`OFS_CIND, 32'h100, 32'h100);
      // Jog from ready; main setpoint changes must not leak in.
      want.jog1 <= 1'b1;
      tick(5);
      chk(`OFS_STAT, 32'h63f, 32'h8);
      chk(`OFS_SPD, 32'hffff, 32'd100);
      wr(`OFS_MAIN, 32'd500);
      tick(2);
      chk(`OFS_SPD, 32'hffff, 32'd100);
      want.freeze <= 1'b1;
      tick(2);
      cmp(32'(frz), 32'h1);
      want.jog2 <= 1'b1;
      tick(4);
      chk(`OFS_SPD, 32'hffff, 32'd100);
      // Withdraw: ramp down, jog again mid-ramp, then stop fully.
      want.jog1 <= 1'b0;
      want.jog2 <= 1'b0;
      want.freeze <= 1'b0;
      tick(3);
      chk(`OFS_STAT, 32'h3f, 32'h4);
      bus(1'b0, `OFS_SPD, 32'h0);
      cmp(32'(rd[15:0] > 0 && rd[15:0] < 100), 32'h1);
      want.jog1 <= 1'b1;
      tick(3);
      chk(`OFS_STAT, 32'h3f, 32'h8);
      want.jog1 <= 1'b0;
      tick(8);
      chk(`OFS_SPD, 32'hffff, 32'h0);
      chk(`OFS_STAT, 32'h3f, 32'h1);
      // On after the jog goes to the summed normal setpoint.
      want.jog1 <= 1'b1;
      tick(4);
      want.jog1 <= 1'b0;
      want.on <= 1'b1;
      tick(14);
      chk(`OFS_STAT, 32'h63f, 32'h202);
      chk(`OFS_SPD, 32'hffff, 32'd550);
      cmp(32'(spd), 32'd550);
      want.jog2 <= 1'b1;
      tick(2);
      chk(`OFS_STAT, 32'h63f, 32'h202);
      want.qstop_n <= 1'b0;
      tick(2);
      chk(`OFS_STAT, 32'h3f, 32'h10);
      tick(7);
      chk(`OFS_SPD, 32'hffff, 32'h0);
      want.on <= 1'b0;
      want.qstop_n <= 1'b1;
      want.jog2 <= 1'b0;
      tick(2);
      chk(`OFS_STAT, 32'h3f, 32'h1);
      // Quick stop blocks a jog start; coast ends a running jog at once.
      want.qstop_n <= 1'b0;
      want.jog1 <= 1'b1;
      tick(3);
      chk(`OFS_STAT, 32'h3f, 32'h1);
      want.qstop_n <= 1'b1;
      tick(3);
      chk(`OFS_STAT, 32'h3f, 32'h8);
      want.coast_n <= 1'b0;
      tick(2);
      chk(`OFS_STAT, 32'h3f, 32'h20);
      chk(`OFS_SPD, 32'hffff, 32'h0);
      want.coast_n <= 1'b1;
      want.jog1 <= 1'b0;
      tick(2);
      // Suppression band pulls 100 down to 50; the minimum lifts it to 120.
      wr(`OFS_BLO, 32'd50);
      wr(`OFS_BHI, 32'd150);
      want.jog1 <= 1'b1;
      tick(4);
      chk(`OFS_SPD, 32'hffff, 32'd50);
      want.jog1 <= 1'b0;
      tick(4);
      wr(`OFS_BHI, 32'h0);
      wr(`OFS_MINS, 32'd120);
      want.jog1 <= 1'b1;
      tick(5);
      chk(`OFS_SPD, 32'hffff, 32'd120);
      want.jog1 <= 1'b0;
      tick(7);
      wr(`OFS_MINS, 32'h0);
      // Without extension the first supplementary input is the setpoint; freeze does nothing.
      wr(`OFS_CFG, 32'h0);
      wr(`OFS_SUP1, 32'd80);
      // A jog held while on arrives from ready must lose to on.
      want.jog1 <= 1'b1;
      wr(`OFS_CTRL, 32'h7);
      tick(4);
      chk(`OFS_SPD, 32'hffff, 32'd80);
      cmp(32'(op_en), 32'h1);
      want.jog1 <= 1'b0;
      wr(`OFS_CTRL, 32'h27);
      wr(`OFS_SUP1, 32'd30);
      tick(5);
      chk(`OFS_SPD, 32'hffff, 32'd30);
      wr(`OFS_CTRL, 32'h6);
      tick(4);
      chk(`OFS_SPD, 32'hffff, 32'h0);
      // Position evaluation: once per control cycle for telegram 5, never for telegram 1.
      wr(`OFS_CFG, 32'h0508);
      tick(1);
      p0 = pulses;
      tick(4);
      cmp(32'(pulses - p0), 32'd4);
      wr(`OFS_CFG, 32'h0108);
      tick(1);
      p0 = pulses;
      tick(4);
      cmp(32'(pulses - p0), 32'd0);
      conclude();
   end
endmodule // jog_setpoint_channel_control_tb
`default_nettype wire
